// *** pkg/srqd_pkg.sv ***
// Summary of operation
// RQ1: Every word carries odd parity in bit zero
// RQ2: Parity check skipped when enable bit cleared; code still checks fixed command words
// RQ3: Transmitted words always carry correct parity
// RQ4: Master sends fixed commands with correct parity
// RQ5: Rejected word discarded, error flagged, marker answered
// RQ6: Parity, length, unknown word, bad address flagged
// RQ7: Mode-forbidden command or busy read flagged
// RQ8: Config entry word accepted only in default/error
// RQ9: Verify entry word accepted only in configuration
// RQ10: Config exit word accepted only in configuration
// RQ11: No-operation accepted everywhere, still fully checked
// RQ12: Read word returns addressed register value
// RQ13: Active and weak active reads range limited
// RQ14: Write-upper loads buffer high byte only
// RQ15: Write-lower loads low byte, commits, clears buffer
// RQ16: Write-lower commit limited to allowed addresses
// RQ17: Commands and writes answered with status word
// RQ18: Master may reset device on persistent marker
// RQ19: Edge counts unequal or not multiple: error
// RQ20: Answers follow one transfer after requests
// RQ21: First word after reset is status word
// RQ22: Shift out on rising, sample on falling
// RQ23: Write buffer is zero after reset
`default_nettype none
package srqd_pkg;
	// Word layout
	localparam int WORD_W = 16;
	localparam int ADDR_W = 5;
	localparam int ADDR_LSB = 7;
	localparam int UP_DATA_LSB = 1;
	localparam int UP_DATA_W = 8;
	localparam int LO_DATA_LSB = 1;
	localparam int LO_DATA_W = 6;
	localparam int MARKER_BIT = 15;
	localparam int CNT_W = 8;
	// Fixed command words, parity included
	localparam logic [15:0] ENTER_CONFIG_CMD = 16'h1880;
	localparam logic [15:0] ENTER_VERIFY_CMD = 16'h1140;
	localparam logic [15:0] LEAVE_CONFIG_CMD = 16'h1220;
	localparam logic [15:0] NOP_CMD = 16'h1410;
	// Pattern commands: mask of fixed bits and their value
	localparam logic [15:0] READ_MASK = 16'hf07e;
	localparam logic [15:0] READ_VAL = 16'h002a;
	localparam logic [15:0] WRITE_UPPER_MASK = 16'hfe00;
	localparam logic [15:0] WRITE_UPPER_CMD = 16'h4400;
	localparam logic [15:0] WRITE_LOWER_MASK = 16'hf000;
	localparam logic [15:0] WRITE_LOWER_COMMIT_CMD = 16'ha000;
	// Reset values
	localparam logic [15:0] ANSWER_RESET = 16'h0001;
	localparam logic [15:0] WBUF_RESET = 16'h0000;
	// Operating mode codes as seen on the mode input
	localparam logic [2:0] default_state = 3'h0;
	localparam logic [2:0] error_state = 3'h1;
	localparam logic [2:0] configuration_state = 3'h2;
	localparam logic [2:0] configured_state = 3'h3;
	localparam logic [2:0] active_state = 3'h4;
	localparam logic [2:0] verification_state = 3'h5;
	localparam logic [2:0] weak_active_state = 3'h6;

	// Decoder sequencing
	typedef enum logic [1:0] {
		SRQD_IDLE,
		SRQD_CHECK,
		SRQD_READ
	} srqd_state_t;

	// Odd parity holds over all sixteen bits
	function automatic logic srqd_par_ok(input logic [15:0] w);
		srqd_par_ok = ^w;
	endfunction : srqd_par_ok

	// Append parity bit so the word has odd weight
	function automatic logic [15:0] srqd_with_par(input logic [14:0] p);
		srqd_with_par = {p, ~(^p)};
	endfunction : srqd_with_par
endpackage : srqd_pkg
`default_nettype wire

// *** verilog/srqd_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module srqd_top (
	// System clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Serial link pins
	input wire logic spi_sclk,
	input wire logic spi_ncs_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	// Configuration and mode context
	input wire logic parity_check_enable,
	input wire logic [2:0] op_mode,
	input wire logic secondary_read_busy,
	input wire logic [31:0] read_allow_mask,
	input wire logic [31:0] write_allow_mask,
	// Status and register read data
	input wire logic [14:0] primary_status_word,
	input wire logic [14:0] reg_rdata,
	// Decoded command pulses and rejection marker
	output logic serial_error_flag,
	output logic enter_config_cmd,
	output logic enter_verify_cmd,
	output logic leave_config_cmd,
	output logic rejected_request_marker,
	// Register access
	output logic reg_rd_req,
	output logic [srqd_pkg::ADDR_W-1:0] reg_raddr,
	output logic reg_we,
	output logic [srqd_pkg::ADDR_W-1:0] reg_waddr,
	output logic [srqd_pkg::WORD_W-1:0] reg_wdata
);
	import srqd_pkg::*;

	// Link-domain state
	logic [15:0] rx_shift_r; // Received bits, newest in bit zero
	logic [CNT_W-1:0] rise_cnt_r; // Rising edges this frame
	logic [CNT_W-1:0] fall_cnt_r; // Falling edges this frame
	logic [3:0] tx_idx_r; // Next bit to shift out
	logic sdo_r; // Output data flop
	// System-domain state
	logic link_clr_r; // Clears link counters between frames
	logic [1:0] ncs_sync_r; // Chip select synchroniser
	logic ncs_d_r; // Delayed synced chip select
	logic [31:0] lnk_m_r; // First stage of link snapshot
	logic [31:0] lnk_s_r; // Second stage of link snapshot
	logic [15:0] rx_pipe_m_r; // First stage of received word
	logic [15:0] rx_s_r; // Received word in clk domain
	srqd_state_t state_r;
	srqd_state_t state_nxt;
	logic [15:0] answer_r; // Word shifted out next frame
	logic hold_read_r; // Answer holds read data
	logic marker_r; // Last request rejected
	logic oe_r; // Output enable flop
	logic err_r;
	logic cfg_r;
	logic ver_r;
	logic lv_r;
	logic rd_req_r;
	logic [ADDR_W-1:0] raddr_r;
	logic we_r;
	logic [ADDR_W-1:0] waddr_r;
	logic [15:0] wdata_r;
	logic [15:0] wbuf_r; // Two-step write buffer

	// Input sampling on falling edges inside the frame
	always_ff @(negedge spi_sclk or posedge link_clr_r) begin
		if (link_clr_r) begin
			rx_shift_r <= 16'h0000;
			fall_cnt_r <= '0;
		end else if (!spi_ncs_n) begin
			rx_shift_r <= {rx_shift_r[14:0], spi_sdi}; // RQ22
			fall_cnt_r <= fall_cnt_r + 1'b1;
		end
	end

	// Output shifting on rising edges, MSB first
	// Answer word is quasi-static: it is frozen while chip select is low
	always_ff @(posedge spi_sclk or posedge link_clr_r) begin
		if (link_clr_r) begin
			tx_idx_r <= 4'h0;
			rise_cnt_r <= '0;
			sdo_r <= 1'b0;
		end else if (!spi_ncs_n) begin
			sdo_r <= answer_r[4'hf - tx_idx_r]; // RQ22
			tx_idx_r <= tx_idx_r + 4'h1;
			rise_cnt_r <= rise_cnt_r + 1'b1;
		end
	end
	assign spi_sdo = sdo_r;

	// Chip select synchroniser, second stage read only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ncs_sync_r <= 2'b11;
			ncs_d_r <= 1'b1;
		end else begin
			ncs_sync_r <= {ncs_sync_r[0], spi_ncs_n};
			ncs_d_r <= ncs_sync_r[1];
		end
	end

	// Link results pass two flops; they are stable once the clock stops
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lnk_m_r <= 32'h0000_0000;
			lnk_s_r <= 32'h0000_0000;
			rx_pipe_m_r <= 16'h0000;
			rx_s_r <= 16'h0000;
		end else begin
			lnk_m_r <= {16'h0000, rise_cnt_r, fall_cnt_r};
			lnk_s_r <= lnk_m_r;
			rx_pipe_m_r <= rx_shift_r;
			rx_s_r <= rx_pipe_m_r;
		end
	end

	// Decode terms
	logic ncs_rise;
	logic cnt_ok;
	logic is_cfg, is_ver, is_lv, is_nop, is_rd, is_wu, is_wl, is_fixed;
	logic par_pass, cfg_ok, ver_ok, lv_ok, rd_ok, wl_ok, accept;
	logic [ADDR_W-1:0] w_addr;
	logic [CNT_W-1:0] rc, fc;
	assign ncs_rise = ncs_sync_r[1] & ~ncs_d_r;
	assign rc = lnk_s_r[2*CNT_W-1:CNT_W];
	assign fc = lnk_s_r[CNT_W-1:0];
	// Equal counts, whole words, at least one word
	assign cnt_ok = (rc == fc) && (rc[3:0] == 4'h0) && (rc != '0); // RQ19 RQ6
	// Fixed words compared without their parity bit
	assign is_cfg = rx_s_r[15:1] == ENTER_CONFIG_CMD[15:1];
	assign is_ver = rx_s_r[15:1] == ENTER_VERIFY_CMD[15:1];
	assign is_lv = rx_s_r[15:1] == LEAVE_CONFIG_CMD[15:1];
	assign is_nop = rx_s_r[15:1] == NOP_CMD[15:1];
	assign is_fixed = is_cfg | is_ver | is_lv | is_nop;
	assign is_rd = (rx_s_r & READ_MASK) == READ_VAL;
	assign is_wu = (rx_s_r & WRITE_UPPER_MASK) == WRITE_UPPER_CMD;
	assign is_wl = (rx_s_r & WRITE_LOWER_MASK) == WRITE_LOWER_COMMIT_CMD;
	assign w_addr = rx_s_r[ADDR_LSB +: ADDR_W];
	// Fixed words must have good parity even when checking is off
	assign par_pass = srqd_par_ok(rx_s_r) | (~parity_check_enable & ~is_fixed); // RQ2 RQ4 RQ1
	assign cfg_ok = is_cfg && (op_mode == default_state || op_mode == error_state); // RQ8
	assign ver_ok = is_ver && (op_mode == configuration_state); // RQ9
	assign lv_ok = is_lv && (op_mode == configuration_state); // RQ10
	// Reads limited by range only in active and weak active
	assign rd_ok = is_rd && !secondary_read_busy && // RQ7
		((op_mode == active_state || op_mode == weak_active_state) ?
		read_allow_mask[w_addr] : 1'b1); // RQ13
	assign wl_ok = is_wl && write_allow_mask[w_addr]; // RQ16
	// Anything not matched is an unknown word and rejected
	assign accept = cnt_ok && par_pass &&
		(cfg_ok | ver_ok | lv_ok | is_nop | rd_ok | is_wu | wl_ok); // RQ6 RQ11

	// Sequencer next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SRQD_IDLE: begin
				if (ncs_rise) begin
					state_nxt = SRQD_CHECK;
				end
			end
			SRQD_CHECK: begin
				state_nxt = (accept && is_rd) ? SRQD_READ : SRQD_IDLE;
			end
			SRQD_READ: begin
				state_nxt = SRQD_IDLE;
			end
			default: begin
				state_nxt = SRQD_IDLE;
			end
		endcase
	end

	// Sequencer state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= SRQD_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Clear link counters during reset and once a frame was taken
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			link_clr_r <= 1'b1;
		end else begin
			link_clr_r <= (state_r == SRQD_CHECK);
		end
	end

	// Output enable follows synced chip select
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			oe_r <= 1'b0;
		end else begin
			oe_r <= ~ncs_sync_r[1];
		end
	end
	assign spi_sdo_oe = oe_r;

	// Answer word for the next transfer; refreshed only while deselected
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			answer_r <= ANSWER_RESET; // RQ21
			hold_read_r <= 1'b0;
			marker_r <= 1'b0;
		end else begin
			case (state_r)
				SRQD_CHECK: begin
					marker_r <= ~accept; // RQ5
					hold_read_r <= 1'b0;
					if (!accept) begin
						answer_r <= srqd_with_par(primary_status_word |
							15'h4000); // RQ5 RQ3
					end else begin
						answer_r <= srqd_with_par(primary_status_word); // RQ17 RQ20
					end
				end
				SRQD_READ: begin
					answer_r <= srqd_with_par(reg_rdata); // RQ12 RQ3
					hold_read_r <= 1'b1;
				end
				default: begin
					// Track live status between frames, not during one
					if (ncs_sync_r[1] && ncs_d_r && !hold_read_r) begin
						answer_r <= srqd_with_par(marker_r ?
							(primary_status_word | 15'h4000) : primary_status_word); // RQ21
					end
				end
			endcase
		end
	end

	// Command and error pulses
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			err_r <= 1'b0;
			cfg_r <= 1'b0;
			ver_r <= 1'b0;
			lv_r <= 1'b0;
		end else begin
			err_r <= (state_r == SRQD_CHECK) && !accept; // RQ5 RQ6 RQ7
			cfg_r <= (state_r == SRQD_CHECK) && accept && cfg_ok; // RQ8
			ver_r <= (state_r == SRQD_CHECK) && accept && ver_ok; // RQ9
			lv_r <= (state_r == SRQD_CHECK) && accept && lv_ok; // RQ10
		end
	end

	// Register read request; read data is taken in the same cycle as the request
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_req_r <= 1'b0;
			raddr_r <= '0;
		end else begin
			rd_req_r <= (state_r == SRQD_CHECK) && accept && is_rd; // RQ12
			if ((state_r == SRQD_CHECK) && accept && is_rd) begin
				raddr_r <= w_addr;
			end
		end
	end

	// Two-step write buffer and commit
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wbuf_r <= WBUF_RESET; // RQ23
			we_r <= 1'b0;
			waddr_r <= '0;
			wdata_r <= 16'h0000;
		end else begin
			we_r <= 1'b0;
			if ((state_r == SRQD_CHECK) && accept && is_wu) begin
				wbuf_r[15:8] <= rx_s_r[UP_DATA_LSB +: UP_DATA_W]; // RQ14
			end else if ((state_r == SRQD_CHECK) && accept && wl_ok) begin
				we_r <= 1'b1; // RQ15
				waddr_r <= w_addr;
				wdata_r <= {wbuf_r[15:8], rx_s_r[LO_DATA_LSB +: LO_DATA_W], 2'b00};
				wbuf_r <= WBUF_RESET; // RQ15
			end
		end
	end

	assign serial_error_flag = err_r;
	assign enter_config_cmd = cfg_r;
	assign enter_verify_cmd = ver_r;
	assign leave_config_cmd = lv_r;
	assign rejected_request_marker = marker_r;
	assign reg_rd_req = rd_req_r;
	assign reg_raddr = raddr_r;
	assign reg_we = we_r;
	assign reg_waddr = waddr_r;
	assign reg_wdata = wdata_r;

	// Checks on the system clock
	logic chk;
	assign chk = (state_r == SRQD_CHECK);

	a_parity_err_flag: assert property (@(posedge clk) disable iff (sys_rst)
		chk && cnt_ok && parity_check_enable && !srqd_par_ok(rx_s_r) |=> err_r) // RQ2
		else $error("bad parity not flagged");
	a_parity_ignored_off: assert property (@(posedge clk) disable iff (sys_rst)
		chk && cnt_ok && !parity_check_enable && is_wu |=> !err_r && wbuf_r[15:8] ==
		$past(rx_s_r[8:1])) // RQ2
		else $error("parity checked while disabled");
	a_tx_parity_odd: assert property (@(posedge clk) disable iff (sys_rst)
		^answer_r) // RQ3
		else $error("answer word has even parity");
	a_fixed_parity_kept: assert property (@(posedge clk) disable iff (sys_rst)
		chk && cnt_ok && is_fixed && !srqd_par_ok(rx_s_r) |=> err_r && !cfg_r) // RQ4
		else $error("fixed word with bad parity accepted");
	a_reject_marker_set: assert property (@(posedge clk) disable iff (sys_rst)
		err_r |-> marker_r && answer_r[MARKER_BIT] && !we_r && !rd_req_r) // RQ5
		else $error("rejected word lacks marker");
	a_frame_count_err: assert property (@(posedge clk) disable iff (sys_rst)
		chk && (rc != fc || rc[3:0] != 4'h0) |=> err_r ##1 !err_r) // RQ19
		else $error("bad edge count not flagged");
	a_enter_cfg_mode: assert property (@(posedge clk) disable iff (sys_rst)
		chk && cnt_ok && rx_s_r == ENTER_CONFIG_CMD |=>
		(cfg_r == ($past(op_mode) <= error_state)) && (err_r != cfg_r)) // RQ8
		else $error("config entry mode gating wrong");
	a_verify_mode_gate: assert property (@(posedge clk) disable iff (sys_rst)
		ver_r |-> $past(op_mode) == configuration_state) // RQ9
		else $error("verify entry outside configuration");
	a_leave_cfg_gate: assert property (@(posedge clk) disable iff (sys_rst)
		lv_r |-> $past(op_mode) == configuration_state && $past(rx_s_r[15:1]) ==
		LEAVE_CONFIG_CMD[15:1]) // RQ10
		else $error("config exit gating wrong");
	a_busy_read_err: assert property (@(posedge clk) disable iff (sys_rst)
		chk && cnt_ok && is_rd && secondary_read_busy |=> err_r && !rd_req_r) // RQ7
		else $error("busy read not rejected");
	a_read_range_err: assert property (@(posedge clk) disable iff (sys_rst)
		chk && is_rd && op_mode == active_state && !read_allow_mask[w_addr] |=> err_r) // RQ13
		else $error("out of range read accepted");
	a_read_answer_data: assert property (@(posedge clk) disable iff (sys_rst)
		rd_req_r |=> answer_r == srqd_with_par($past(reg_rdata, 1)) && hold_read_r) // RQ12
		else $error("read answer not returned");
	a_write_commit_clr: assert property (@(posedge clk) disable iff (sys_rst)
		we_r |-> wbuf_r == 16'h0000 && wdata_r[1:0] == 2'b00 &&
		$past(write_allow_mask[w_addr]) && waddr_r == $past(w_addr)) // RQ15 RQ16
		else $error("write commit wrong");

	c_write_pair: cover property (@(posedge clk) disable iff (sys_rst)
		chk && accept && is_wu ##[1:200] we_r);
	c_read_done: cover property (@(posedge clk) disable iff (sys_rst)
		rd_req_r ##1 hold_read_r);
	c_reject: cover property (@(posedge clk) disable iff (sys_rst) err_r);
	c_cfg_enter: cover property (@(posedge clk) disable iff (sys_rst) cfg_r);
endmodule : srqd_top
`default_nettype wire

// *** bench/srqd_host.sv ***
`timescale 1ns/1ns
`default_nettype none
// Serial master model; its clock stands low outside frames
module srqd_host (
	// Link pins
	output logic spi_sclk,
	output logic spi_ncs_n,
	output logic spi_sdi,
	input wire logic spi_sdo,
	input wire logic spi_sdo_oe
);
	// Idle bus from time zero
	initial begin
		spi_sclk = 1'b0;
		spi_ncs_n = 1'b1;
		spi_sdi = 1'b0;
	end

	// One frame of n bits, MSB first, 32 ns clock period
	task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] ans);
		ans = '0;
		// Step off the system edge that called us
		#1;
		spi_ncs_n = 1'b0;
		// First rising edge well after select falls
		#20;
		for (int i = n - 1; i >= 0; i--) begin
			// Data changes on rising, device takes it on falling
			spi_sclk = 1'b1;
			spi_sdi = w[i];
			#16;
			// Answer bit settled half a period after rising
			ans = {ans[30:0], spi_sdo};
			spi_sclk = 1'b0;
			#16;
		end
		spi_ncs_n = 1'b1;
		// Released line never keeps the last bit
		spi_sdi = ~spi_sdi;
		// Gap between frames well above the minimum
		#60;
	endtask : xfer
endmodule : srqd_host
`default_nettype wire

// *** bench/spi_request_decoder_with_parity_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module spi_request_decoder_with_parity_tb;
	import srqd_pkg::*;
	// Clock, reset and context inputs
	logic clk = 1'b0, sys_rst = 1'b1, pce = 1'b1, busy = 1'b0;
	logic [2:0] op_mode = 3'h0;
	logic [31:0] rd_mask = 32'h0, wr_mask = 32'h0;
	logic [14:0] st = 15'h1234;
	wire logic [14:0] reg_rdata;
	// Link and design outputs
	wire logic sclk, ncs_n, sdi;
	logic sdo, sdo_oe, s_err, c_cfg, c_ver, c_lv, marker, rd_req, we;
	logic [4:0] raddr, waddr;
	logic [15:0] wdata, wd_q = 16'h0, pend;
	logic [4:0] wa_q = 5'h0;
	// Event counters and bookkeeping
	int n_err = 0, n_cfg = 0, n_ver = 0, n_lv = 0, n_we = 0, cyc = 0;
	int n_rd = 0, n_oe = 0;
	int err_total = 0, checks_done = 0;

	always #2 clk = ~clk;

	srqd_top i_srqd_top (.clk(clk), .sys_rst(sys_rst), .spi_sclk(sclk), .spi_ncs_n(ncs_n),
		.spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .parity_check_enable(pce),
		.op_mode(op_mode), .secondary_read_busy(busy), .read_allow_mask(rd_mask),
		.write_allow_mask(wr_mask), .primary_status_word(st), .reg_rdata(reg_rdata),
		.serial_error_flag(s_err), .enter_config_cmd(c_cfg), .enter_verify_cmd(c_ver),
		.leave_config_cmd(c_lv), .rejected_request_marker(marker), .reg_rd_req(rd_req),
		.reg_raddr(raddr), .reg_we(we), .reg_waddr(waddr), .reg_wdata(wdata));
	srqd_host i_srqd_host (.spi_sclk(sclk), .spi_ncs_n(ncs_n), .spi_sdi(sdi),
		.spi_sdo(sdo), .spi_sdo_oe(sdo_oe));

	// Pulse counters, output enable cycles and last write seen
	always @(posedge clk) begin
		n_err <= n_err + (s_err === 1'b1);
		n_rd <= n_rd + (rd_req === 1'b1);
		n_oe <= n_oe + (sdo_oe === 1'b1);
		n_cfg <= n_cfg + (c_cfg === 1'b1);
		n_ver <= n_ver + (c_ver === 1'b1);
		n_lv <= n_lv + (c_lv === 1'b1);
		n_we <= n_we + (we === 1'b1);
		if (we === 1'b1) begin
			wa_q <= waddr;
			wd_q <= wdata;
		end
	end
	// Register file stand-in; data follows the held address with no delay
	assign reg_rdata = {10'h2aa, raddr};

	// Hang guard, far above the expected run length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (err_total == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Odd parity in bit zero over the payload
	function automatic logic [15:0] mk(input logic [15:0] w);
		mk = {w[15:1], ~^w[15:1]};
	endfunction : mk
	function automatic logic [15:0] rd(input logic [4:0] a);
		rd = mk({4'h0, a, 7'h2a});
	endfunction : rd
	function automatic logic [15:0] wl(input logic [4:0] a, input logic [5:0] d);
		wl = mk({4'ha, a, d, 1'b0});
	endfunction : wl
	function automatic logic [15:0] wu(input logic [7:0] d);
		wu = mk({7'h22, d, 1'b0});
	endfunction : wu
	function automatic logic [15:0] ok();
		ok = mk({st, 1'b0});
	endfunction : ok
	function automatic logic [15:0] rej();
		rej = mk({1'b1, st[13:0], 1'b0});
	endfunction : rej

	// One transfer: judge the answer owed by the previous one, then this request's pulses
	task automatic req(input logic [31:0] w, input int n, input logic e, input logic [2:0] c,
		input logic [15:0] nxt);
		int e0, c0, c1, c2, o0;
		logic [31:0] a;
		e0 = n_err;
		o0 = n_oe;
		c0 = n_cfg;
		c1 = n_ver;
		c2 = n_lv;
		i_srqd_host.xfer(w, n, a);
		repeat (20) @(posedge clk);
		if (n < 16) chk("short answer", a[14:0], pend[15:1]);
		else chk("answer", a[15:0], pend);
		chk("error pulses", n_err - e0, e);
		chk("mode pulses", (n_cfg - c0) + 2 * (n_ver - c1) + 4 * (n_lv - c2),
			c);
		// Select stands low 20 ns plus 32 ns a bit; enable lags both ends by the synchroniser
		chk("oe cycles", n_oe - o0, 5 + 8 * n);
		chk("oe idle", sdo_oe, 1'b0);
		pend = nxt;
	endtask : req

	// Every mode command in every mode, then a no-operation
	task automatic t_modes();
		logic g;
		for (int m = 0; m < 7; m++) begin
			@(posedge clk) op_mode <= 3'(m);
			g = (m <= 1);
			req(ENTER_CONFIG_CMD, 16, !g, g ? 3'b001 : 3'b000, g ? ok() : rej());
			g = (m == 2);
			req(ENTER_VERIFY_CMD, 16, !g, g ? 3'b010 : 3'b000, g ? ok() : rej());
			req(LEAVE_CONFIG_CMD, 16, !g, g ? 3'b100 : 3'b000, g ? ok() : rej());
			req(NOP_CMD, 16, 1'b0, 3'b000, ok());
		end
	endtask : t_modes

	// Parity on and off, unknown word, short and double-length frames
	task automatic t_parity();
		@(posedge clk) op_mode <= 3'h0;
		req(NOP_CMD ^ 16'h1, 16, 1'b1, 3'b000, rej());
		@(posedge clk) pce <= 1'b0;
		req(NOP_CMD ^ 16'h1, 16, 1'b1, 3'b000, rej());
		req(rd(5'd3) ^ 16'h1, 16, 1'b0, 3'b000, mk({10'h2aa, 5'd3, 1'b0}));
		req(mk(16'h3000), 16, 1'b1, 3'b000, rej());
		req(NOP_CMD, 15, 1'b1, 3'b000, rej());
		req({NOP_CMD, NOP_CMD}, 32, 1'b0, 3'b000, ok());
		@(posedge clk) pce <= 1'b1;
	endtask : t_parity

	// Range limited reads in the enabled modes, and a busy read
	task automatic t_read();
		@(posedge clk) begin
			op_mode <= active_state;
			rd_mask <= 32'h0000_0008;
		end
		req(rd(5'd3), 16, 1'b0, 3'b000, mk({10'h2aa, 5'd3, 1'b0}));
		req(rd(5'd4), 16, 1'b1, 3'b000, rej());
		@(posedge clk) busy <= 1'b1;
		req(rd(5'd3), 16, 1'b1, 3'b000, rej());
		@(posedge clk) begin
			busy <= 1'b0;
			op_mode <= weak_active_state;
		end
		req(rd(5'd9), 16, 1'b1, 3'b000, rej());
		// Only the unchecked read and the in-range read reached the registers
		chk("reads", n_rd, 2);
	endtask : t_read

	// Two-step writes, buffer clearing, and a refused commit
	task automatic t_write();
		@(posedge clk) begin
			op_mode <= configured_state;
			wr_mask <= 32'h0000_0020;
		end
		req(wl(5'd5, 6'h2d), 16, 1'b0, 3'b000, ok());
		chk("wdata", wd_q, 16'h00b4);
		req(wu(8'ha5), 16, 1'b0, 3'b000, ok());
		chk("writes", n_we, 1);
		req(wl(5'd5, 6'h11), 16, 1'b0, 3'b000, ok());
		chk("wdata", wd_q, 16'ha544);
		chk("waddr", wa_q, 5'd5);
		req(wl(5'd5, 6'h01), 16, 1'b0, 3'b000, ok());
		chk("wdata", wd_q, 16'h0004);
		// Upper byte with bad parity is taken while checking is off
		@(posedge clk) pce <= 1'b0;
		req(wu(8'h5a) ^ 16'h1, 16, 1'b0, 3'b000, ok());
		@(posedge clk) pce <= 1'b1;
		req(wl(5'd6, 6'h01), 16, 1'b1, 3'b000, rej());
		req(NOP_CMD, 16, 1'b0, 3'b000, ok());
		chk("writes", n_we, 3);
		// A refused commit leaves the buffer alone
		req(wl(5'd5, 6'h03), 16, 1'b0, 3'b000, ok());
		chk("wdata", wd_q, 16'h5a0c);
	endtask : t_write

	// Reset in mid-run clears a persisting marker; first answer is status again
	task automatic t_reset();
		req(mk(16'h3000), 16, 1'b1, 3'b000, rej());
		chk("marker", marker, 1'b1);
		@(posedge clk) sys_rst <= 1'b1;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (8) @(posedge clk);
		chk("marker after reset", marker, 1'b0);
		chk("oe after reset", sdo_oe, 1'b0);
		pend = ok();
		req(NOP_CMD, 16, 1'b0, 3'b000, ok());
	endtask : t_reset

	// Main sequence
	initial begin
		// First answer after reset is the status word
		pend = ok();
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (8) @(posedge clk);
		t_modes();
		t_parity();
		t_read();
		t_write();
		t_reset();
		finish_test();
	end
endmodule : spi_request_decoder_with_parity_tb
`default_nettype wire
